// ===== bench/dwr_core_props.sv
// Checker for refresh and beat outputs of the command block
`timescale 1ns/1ps
`include "dwr_params.svh"
module dwr_core_props
(
	input wire logic                   sysClk,
	input wire logic                   arst_n,
	input wire logic                   beatValid,
	input wire logic                   beatReady,
	input wire logic [`DWR_DQ_W-1:0]   beatData,
	input wire logic [2:0]             beatIndex,
	input wire logic                   burstFault,
	input wire logic                   refreshActive,
	input wire logic                   refreshDone,
	input wire logic [`DWR_ADDR_W-1:0] refreshRow,
	input wire logic [`DWR_NBANK-1:0]  banksOpen,
	input wire logic                   allIdle
);
	default clocking @(posedge sysClk); endclocking
	default disable iff (!arst_n);
	// Refresh busy phase, then its closing pulse
	sequence refRun;
		refreshActive [*4];
	endsequence
	sequence refEnd;
		##[1:3] (refreshDone && !refreshActive);
	endsequence
	a_ref_length: assert property ($rose(refreshActive) |-> refRun ##0 refEnd)
		else $error("refresh cycle length wrong");
	a_done_single: assert property (refreshDone |=> !refreshDone)
		else $error("refresh done longer than one cycle");
	a_row_step: assert property ($changed(refreshRow) |-> refreshRow == $past(refreshRow) + 1'b1)
		else $error("refresh row did not step by one");
	a_row_on_ref: assert property ($rose(refreshActive) |-> refreshRow != $past(refreshRow, 2))
		else $error("refresh row not advanced");
	a_banks_closed: assert property (refreshDone |-> banksOpen == '0)
		else $error("bank open after refresh");
	a_idle_after_ref: assert property (refreshDone |-> allIdle)
		else $error("block not idle after refresh");
	a_fault_pulse: assert property (burstFault |=> !burstFault)
		else $error("burst fault not a pulse");
	// Stalled beat must not slip under the drain
	a_beat_hold: assert property (beatValid && !beatReady |=> beatValid && $stable(beatData) && $stable(beatIndex))
		else $error("stalled beat changed");
endmodule

bind dwr_core dwr_core_props u_props (.sysClk(sysClk), .arst_n(arst_n), .beatValid(beatValid),
	.beatReady(beatReady), .beatData(beatData), .beatIndex(beatIndex), .burstFault(burstFault),
	.refreshActive(refreshActive), .refreshDone(refreshDone), .refreshRow(refreshRow),
	.banksOpen(banksOpen), .allIdle(allIdle));

// ===== bench/dwr_ctrl_model.sv
// Memory controller model driving command, strobe and data pins
`timescale 1ns/1ps
`include "dwr_params.svh"
module dwr_ctrl_model
(
	input  wire logic                sysClk,
	input  wire logic                arst_n,
	output logic                     ckPin,
	output logic [3:0]               cmd,
	output logic [`DWR_ADDR_W-1:0]   addr,
	output logic [`DWR_BANK_W-1:0]   bank,
	output logic                     dqs,
	output logic [`DWR_DQ_W-1:0]     dq,
	output logic                     dm
);
	logic [2:0] ph;
	initial
	begin
		cmd = 4'hF;
		addr = '0;
		bank = '0;
		dqs = 1'b0;
		dq = '0;
		dm = 1'b0;
	end
	// Command clock runs free, 8 system clocks a period
	always_ff @(posedge sysClk or negedge arst_n)
		if (!arst_n)
			ph <= '0;
		else
			ph <= ph + 3'd1;
	assign ckPin = ph[2];
	task automatic tick(input int n);
		repeat (n) @(posedge sysClk);
	endtask
	// pins held around the clock rise, then address scrambled
	task automatic issue(input logic [3:0] c, input logic [13:0] a, input logic [2:0] b);
		repeat (8)
		begin
			@(posedge sysClk);
			if (ph == 3'd0)
				break;
		end
		cmd <= c;
		addr <= a;
		bank <= b;
		tick(8);
		cmd <= 4'hF;
		addr <= ~a;
		bank <= ~b;
	endtask
	// data and mask settle well before each strobe edge
	task automatic burst(input int n, input logic [7:0] d0, input logic [7:0] m);
		for (int i = 0; i < n; i++)
		begin
			dq <= d0 + 8'(i);
			dm <= m[i];
			tick(4);
			dqs <= ~dqs;
			tick(4);
		end
		dq <= ~dq;
		dm <= ~dm;
	endtask
endmodule

// ===== bench/test_dwr_core.sv
// Self-checking bench for the write and refresh command block
`timescale 1ns/1ps
`include "dwr_params.svh"
module test_dwr_core;
	logic        sysClk = 1'b0;
	logic        arst_n = 1'b0;
	logic [1:0]  burstMode = 2'h0;
	logic        tdqsEnable = 1'b0;
	logic        beatReady = 1'b1;
	logic        ckPin, dqsPin, dmPin, beatValid, beatMask, beatFault;
	logic        burstFault, refreshActive, refreshDone, allIdle;
	logic [3:0]  cmd;
	logic [2:0]  bank, beatIndex, beatBank;
	logic [7:0]  dq, beatData, banksOpen;
	logic [9:0]  beatCol;
	logic [13:0] addr, row0, refreshRow;
	logic [25:0] got[$];
	int          err_count = 0, n_checks = 0, nFault = 0, nDone = 0;
	always #12.5 sysClk = ~sysClk;
	dwr_ctrl_model ctl (.sysClk(sysClk), .arst_n(arst_n), .ckPin(ckPin), .cmd(cmd), .addr(addr),
		.bank(bank), .dqs(dqsPin), .dq(dq), .dm(dmPin));
	dwr_core dut (.sysClk(sysClk), .arst_n(arst_n), .ckPin(ckPin), .csPin_n(cmd[3]), .rasPin_n(cmd[2]),
		.casPin_n(cmd[1]), .wePin_n(cmd[0]), .addrPin(addr), .bankPin(bank), .dqsPin(dqsPin),
		.dqPin(dq), .dmPin(dmPin), .burstMode(burstMode), .tdqsEnable(tdqsEnable),
		.beatValid(beatValid), .beatReady(beatReady), .beatData(beatData), .beatMask(beatMask),
		.beatBank(beatBank), .beatCol(beatCol), .beatIndex(beatIndex), .beatFault(beatFault),
		.burstFault(burstFault), .refreshActive(refreshActive), .refreshDone(refreshDone),
		.refreshRow(refreshRow), .banksOpen(banksOpen), .allIdle(allIdle));
	// Collect drained beats and count pulses
	always @(posedge sysClk)
	begin
		if (beatValid && beatReady)
			got.push_back({beatBank, beatCol, beatFault, beatMask, beatIndex, beatData});
		nFault += int'(burstFault === 1'b1);
		nDone += int'(refreshDone === 1'b1);
	end
	task automatic end_of_test();
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [25:0] e, input logic [25:0] g);
		n_checks++;
		if (g !== e)
		begin
			err_count++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Bounded wait for a pulse counter to move
	task automatic waitNew(ref int c, input int v);
		for (int t = 0; t < 400 && c == v; t++)
			@(posedge sysClk);
		if (c == v)
		begin
			err_count++;
			$display("ERROR pulse wait expected pulse seen none");
			end_of_test();
		end
	endtask
	task automatic expectBeats(input int n, input logic [2:0] b, input logic [9:0] col, input logic [7:0] d0,
		input logic [7:0] m);
		repeat (60) @(posedge sysClk);
		chk("beat count", 26'(n), 26'(got.size()));
		for (int i = 0; i < n && i < got.size(); i++)
			chk("beat", {b, col, 1'b0, m[i], 3'(i), d0 + 8'(i)}, got[i]);
		got.delete();
	endtask
	// Every burst mode, chop bit both ways; chop bit kept out of the column
	task automatic t_modes();
		logic [1:0] mv[4] = '{2'h0, 2'h1, 2'h1, 2'h2};
		logic       av[4] = '{1'b0, 1'b1, 1'b0, 1'b1};
		int         nv[4] = '{8, 8, 4, 4};
		for (int k = 0; k < 4; k++)
		begin
			burstMode <= mv[k];
			ctl.issue(`DWR_CMD_WRITE, {1'b0, av[k], 2'b00, 10'h0F0}, 3'd1);
			ctl.burst(8, 8'(k * 16), 8'hC3);
			// Next command waits as after a full burst, chopped or not
			expectBeats(nv[k], 3'd1, 10'h0F0, 8'(k * 16), 8'hC3);
		end
	endtask
	task automatic t_tdqs_read();
		tdqsEnable <= 1'b1;
		burstMode <= `DWR_BL_FIXED8;
		ctl.issue(`DWR_CMD_WRITE, 14'h0003, 3'd4);
		ctl.burst(8, 8'h80, 8'hFF);
		expectBeats(8, 3'd4, 10'h003, 8'h80, 8'h00);
		tdqsEnable <= 1'b0;
		ctl.issue(`DWR_CMD_READ, 14'h1000, 3'd0);
		ctl.burst(8, 8'h55, 8'hFF);
		expectBeats(0, 3'd0, 10'h0, 8'h0, 8'h0);
	endtask
	// Short burst times out; next write must still land
	task automatic t_timeout();
		int f;
		f = nFault;
		ctl.issue(`DWR_CMD_WRITE, 14'h0000, 3'd0);
		ctl.burst(3, 8'h00, 8'h00);
		waitNew(nFault, f);
		repeat (10) @(posedge sysClk);
		got.delete();
		burstMode <= `DWR_BL_FIXED4;
		ctl.issue(`DWR_CMD_WRITE, 14'h0155, 3'd6);
		ctl.burst(4, 8'hA0, 8'h06);
		expectBeats(4, 3'd6, 10'h155, 8'hA0, 8'h06);
	endtask
	// Drain stalls while three bursts arrive
	task automatic t_fill();
		int f;
		f = nFault;
		beatReady <= 1'b0;
		burstMode <= `DWR_BL_FIXED8;
		for (int k = 0; k < 3; k++)
		begin
			ctl.issue(`DWR_CMD_WRITE, 14'h0000, 3'd0);
			ctl.burst(8, 8'(k * 8), 8'h00);
		end
		waitNew(nFault, f);
		beatReady <= 1'b1;
		repeat (60) @(posedge sysClk);
		chk("fill count", 26'h1, 26'(got.size() inside {[16:18]}));
		for (int i = 0; i < 16 && i < got.size(); i++)
			chk("kept", 26'((i % 8) << 8 | i), got[i]);
		got.delete();
	endtask
	task automatic t_refresh();
		int d;
		ctl.issue(`DWR_CMD_ACT, 14'h0000, 3'd5);
		repeat (8) @(posedge sysClk);
		chk("open", 26'h20, 26'(banksOpen));
		ctl.issue(`DWR_CMD_PRE, 14'h0400, 3'd0);
		repeat (8) @(posedge sysClk);
		chk("idle", 26'h1, 26'(allIdle));
		// two refreshes in turn, each must step the row counter by one
		for (int k = 0; k < 2; k++)
		begin
			row0 = refreshRow;
			d = nDone;
			ctl.issue(`DWR_CMD_REF, 14'h3FFF - 14'(k), 3'd7);
			waitNew(nDone, d);
			repeat (40) @(posedge sysClk); // only idle commands after the refresh cycle
			chk("row", 26'(row0 + 14'd1), 26'(refreshRow));
			chk("banks", 26'h0, 26'(banksOpen));
			chk("single", 26'(d + 1), 26'(nDone));
		end
	endtask
	initial
	begin
		repeat (3) @(posedge sysClk);
		arst_n <= 1'b1;
		repeat (4) @(posedge sysClk);
		t_modes();
		t_tdqs_read();
		t_timeout();
		t_fill();
		t_refresh();
		end_of_test();
	end
endmodule

// ===== rtl/dwr_core.sv
// Device-side write burst capture and refresh command handling
// Behaviour
// - With on-the-fly mode, A12 low gives four-beat chop, high gives eight beats.
// - A12 never enters the column address of a read or write.
// - Data timing slips only corrupt the offending burst; block keeps running.
// - Strobe timing slips corrupt the offending burst and a write queued behind it; no reinitialisation needed.
// - One mask bit per eight data bits, captured like a data bit.
// - Mask input ignored outside write bursts, reads included.
// - Byte-wide part: mask pin becomes termination strobe when enabled.
// - Burst field 00 eight beats, 01 on the fly, 10 fixed chop.
// - Refresh decoded from cs, ras, cas low, we high; one per command.
// - Refresh rows come from an internal counter; address bus ignored.
// - After refresh all banks are precharged and idle.
`timescale 1ns/1ps
`include "dwr_params.svh"
module dwr_core
(
	input  wire logic                      sysClk,
	input  wire logic                      arst_n,
	input  wire logic                      ckPin,
	input  wire logic                      csPin_n,
	input  wire logic                      rasPin_n,
	input  wire logic                      casPin_n,
	input  wire logic                      wePin_n,
	input  wire logic [`DWR_ADDR_W-1:0]    addrPin,
	input  wire logic [`DWR_BANK_W-1:0]    bankPin,
	input  wire logic                      dqsPin,
	input  wire logic [`DWR_DQ_W-1:0]      dqPin,
	input  wire logic                      dmPin,
	input  wire logic [1:0]                burstMode,
	input  wire logic                      tdqsEnable,
	output logic                           beatValid,
	input  wire logic                      beatReady,
	output logic      [`DWR_DQ_W-1:0]      beatData,
	output logic                           beatMask,
	output logic      [`DWR_BANK_W-1:0]    beatBank,
	output logic      [`DWR_COL_W-1:0]     beatCol,
	output logic      [2:0]                beatIndex,
	output logic                           beatFault,
	output logic                           burstFault,
	output logic                           refreshActive,
	output logic                           refreshDone,
	output logic      [`DWR_ADDR_W-1:0]    refreshRow,
	output logic      [`DWR_NBANK-1:0]     banksOpen,
	output logic                           allIdle
);

	localparam logic [7:0] TRFC_CYC = 8'(`DWR_TRFC_CYC);

	logic [`DWR_SYNC_W-1:0]      syncA;
	logic [`DWR_SYNC_W-1:0]      syncB;
	wire  [`DWR_SYNC_W-1:0]      pinVec;
	logic                        ckPrev;
	logic                        dqsPrev;

	dwr_pkg::dwr_state_e         state;
	dwr_pkg::dwr_state_e         next_state;

	logic [`DWR_BANK_W-1:0]      curBank;
	logic [`DWR_COL_W-1:0]       curCol;
	logic [3:0]                  beatsNeeded;
	logic [3:0]                  beatCnt;
	logic                        curErr;
	logic [7:0]                  ckCnt;
	logic                        pendWrite;
	logic [`DWR_BANK_W-1:0]      pendBank;
	logic [`DWR_COL_W-1:0]       pendCol;
	logic                        pendChop;
	logic [7:0]                  refCnt;
	logic                        holdValid;
	logic [`DWR_ENTRY_W-1:0]     holdData;
	logic                        fifoInReady;
	logic [`DWR_ENTRY_W-1:0]     fifoOut;
	logic [`DWR_NBANK-1:0]       next_banksOpen;

	// All pins arrive from the link side, so every bit gets two flops
	assign pinVec = {ckPin, csPin_n, rasPin_n, casPin_n, wePin_n, addrPin, bankPin, dqsPin, dqPin, dmPin};

	genvar gi;
	generate
		for (gi = 0; gi < `DWR_SYNC_W; gi++)
		begin : gSync
			always_ff @(posedge sysClk or negedge arst_n)
			begin
				if (!arst_n)
				begin
					syncA[gi] <= 1'b1;
					syncB[gi] <= 1'b1;
				end
				else
				begin
					syncA[gi] <= pinVec[gi];
					syncB[gi] <= syncA[gi];
				end
			end
		end
	endgenerate

	// Previous levels for edge finding, taken from the second stage only
	always_ff @(posedge sysClk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ckPrev  <= 1'b1;
			dqsPrev <= 1'b1;
		end
		else
		begin
			ckPrev  <= syncB[`DWR_SV_CK];
			dqsPrev <= syncB[`DWR_SV_DQS];
		end
	end

	// Decode of the synchronised command bus
	wire                     ckRise  = syncB[`DWR_SV_CK] & ~ckPrev;
	wire                     dqsEdge = syncB[`DWR_SV_DQS] ^ dqsPrev;
	wire [3:0]               cmdBits = syncB[`DWR_SV_CMD_HI:`DWR_SV_CMD_LO];
	wire [`DWR_ADDR_W-1:0]   addrS   = syncB[`DWR_SV_ADDR_HI:`DWR_SV_ADDR_LO];
	wire [`DWR_BANK_W-1:0]   bankS   = syncB[`DWR_SV_BA_HI:`DWR_SV_BA_LO];
	wire [`DWR_DQ_W-1:0]     dqS     = syncB[`DWR_SV_DQ_HI:`DWR_SV_DQ_LO];
	wire                     dmS     = syncB[`DWR_SV_DM];
	wire                     isRef   = ckRise & (cmdBits == `DWR_CMD_REF);
	wire                     isWrite = ckRise & (cmdBits == `DWR_CMD_WRITE);
	wire                     isAct   = ckRise & (cmdBits == `DWR_CMD_ACT);
	wire                     isPre   = ckRise & (cmdBits == `DWR_CMD_PRE);

	// A12 picks chop or full burst on the fly
	wire cmdChop = (burstMode == `DWR_BL_FIXED4) |
	               ((burstMode == `DWR_BL_OTF) & ~addrS[`DWR_A_CHOP]);
	// column drops A12 and upper bits
	wire [`DWR_COL_W-1:0] cmdCol = addrS[`DWR_COL_MSB:0];

	// mask pin is a termination strobe when enabled
	// mask captured with the same edge as data
	wire beatMaskBit = tdqsEnable ? 1'b0 : dmS;

	// Burst bookkeeping terms
	wire inWdata    = (state == dwr_pkg::DWR_WDATA);
	// mask and data only taken inside a write burst
	wire takeBeat   = inWdata & dqsEdge & (beatCnt != beatsNeeded);
	// overrun marks only the current burst
	wire overrun    = takeBeat & holdValid & ~fifoInReady;
	wire burstFull  = (beatCnt == beatsNeeded) & ~holdValid;
	// missing strobe edges end the burst after a window
	wire timeout    = inWdata & (ckCnt == `DWR_WINDOW_CK);
	wire burstEnd   = inWdata & (burstFull | timeout);
	wire refEnd     = (state == dwr_pkg::DWR_REFRESH) & (refCnt == 8'h00);

	// Next state selection
	always_comb
	begin
		next_state = state;
		case (state)
			dwr_pkg::DWR_IDLE:
			begin
				if (isWrite)
					next_state = dwr_pkg::DWR_WDATA;
				else if (isRef)
					next_state = dwr_pkg::DWR_REFRESH;
			end
			dwr_pkg::DWR_WDATA:
			begin
				if (burstEnd & ~pendWrite)
					next_state = dwr_pkg::DWR_IDLE;
			end
			dwr_pkg::DWR_REFRESH:
			begin
				if (refEnd)
					next_state = dwr_pkg::DWR_IDLE;
			end
			default:
				next_state = dwr_pkg::DWR_IDLE;
		endcase
	end

	always_ff @(posedge sysClk or negedge arst_n)
	begin
		if (!arst_n)
			state <= dwr_pkg::DWR_IDLE;
		else
			state <= next_state;
	end

	// Burst setup, beat counting and a one-deep queue for a following write
	always_ff @(posedge sysClk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			curBank     <= '0;
			curCol      <= '0;
			beatsNeeded <= `DWR_BEATS_BL8;
			beatCnt     <= 4'h0;
			curErr      <= 1'b0;
			ckCnt       <= 8'h00;
			pendWrite   <= 1'b0;
			pendBank    <= '0;
			pendCol     <= '0;
			pendChop    <= 1'b0;
		end
		else if (state == dwr_pkg::DWR_IDLE)
		begin
			if (isWrite)
			begin
				curBank     <= bankS;
				curCol      <= cmdCol;
				beatsNeeded <= cmdChop ? `DWR_BEATS_BC4 : `DWR_BEATS_BL8;
				beatCnt     <= 4'h0;
				curErr      <= 1'b0;
				ckCnt       <= 8'h00;
			end
		end
		else if (inWdata)
		begin
			if (isWrite)
			begin
				pendWrite <= 1'b1;
				pendBank  <= bankS;
				pendCol   <= cmdCol;
				pendChop  <= cmdChop;
			end
			if (burstEnd & pendWrite)
			begin
				// Fault state never carries into the next burst
				curBank     <= pendBank;
				curCol      <= pendCol;
				beatsNeeded <= pendChop ? `DWR_BEATS_BC4 : `DWR_BEATS_BL8;
				beatCnt     <= 4'h0;
				curErr      <= 1'b0;
				ckCnt       <= 8'h00;
				pendWrite   <= isWrite;
			end
			else
			begin
				if (takeBeat & ~overrun)
					beatCnt <= 4'(beatCnt + 1'b1);
				if (overrun)
					curErr <= 1'b1;
				if (ckRise)
					ckCnt <= 8'(ckCnt + 1'b1);
			end
		end
	end

	// Holding stage stalls on a full FIFO instead of dropping the beat
	always_ff @(posedge sysClk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			holdValid <= 1'b0;
			holdData  <= '0;
		end
		else
		begin
			if (takeBeat & ~overrun)
			begin
				holdValid <= 1'b1;
				holdData  <= {curErr, curBank, curCol, beatCnt[2:0], beatMaskBit, dqS};
			end
			else if (fifoInReady)
				holdValid <= 1'b0;
		end
	end

	dwr_fifo
	#(
		.WIDTH (`DWR_ENTRY_W),
		.DEPTH (`DWR_FIFO_DEPTH)
	)
	uFifo
	(
		.sysClk   (sysClk),
		.arst_n   (arst_n),
		.inValid  (holdValid),
		.inReady  (fifoInReady),
		.inData   (holdData),
		.outValid (beatValid),
		.outReady (beatReady),
		.outData  (fifoOut)
	);

	// Field split of the FIFO word
	assign beatFault = fifoOut[25];
	assign beatBank  = fifoOut[24:22];
	assign beatCol   = fifoOut[21:12];
	assign beatIndex = fifoOut[11:9];
	assign beatMask  = fifoOut[8];
	assign beatData  = fifoOut[7:0];

	// Bank open tracking from activate and precharge
	always_comb
	begin
		next_banksOpen = banksOpen;
		if (isAct)
			next_banksOpen[bankS] = 1'b1;
		if (isPre & addrS[`DWR_A_ALLBANK])
			next_banksOpen = `DWR_BANKS_RST;
		else if (isPre)
			next_banksOpen[bankS] = 1'b0;
		// refresh completion leaves every bank precharged
		if (refEnd)
			next_banksOpen = `DWR_BANKS_RST;
	end

	// Refresh timer, internal row counter and status pulses
	always_ff @(posedge sysClk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			refCnt      <= 8'h00;
			refreshRow  <= `DWR_ROW_RST;
			refreshDone <= 1'b0;
			burstFault  <= 1'b0;
			banksOpen   <= `DWR_BANKS_RST;
		end
		else
		begin
			banksOpen   <= next_banksOpen;
			refreshDone <= refEnd;
			burstFault  <= (burstEnd & (timeout | curErr)) | (inWdata & overrun);
			if ((state == dwr_pkg::DWR_IDLE) & isRef)
			begin
				// internal row counter, moves only on refresh
				refreshRow <= `DWR_ADDR_W'(refreshRow + 1'b1);
				// one refresh of five system clocks per command, never repeats itself
				refCnt     <= 8'(TRFC_CYC - 1'b1);
			end
			else if ((state == dwr_pkg::DWR_REFRESH) & (refCnt != 8'h00))
				refCnt <= 8'(refCnt - 1'b1);
		end
	end

	assign refreshActive = (state == dwr_pkg::DWR_REFRESH);
	assign allIdle       = (banksOpen == `DWR_BANKS_RST) & (state == dwr_pkg::DWR_IDLE);

endmodule

// ===== rtl/dwr_fifo.sv
// Beat FIFO with registered read data
`timescale 1ns/1ps
module dwr_fifo
#(
	parameter int WIDTH = 26,
	parameter int DEPTH = 16
)
(
	input  wire logic             sysClk,
	input  wire logic             arst_n,
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	output logic                  outValid,
	input  wire logic             outReady,
	output logic      [WIDTH-1:0] outData
);

	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wrPtr;
	logic [AW-1:0]    rdPtr;
	logic [AW:0]      count;
	wire              push;
	wire              pop;

	// Full only when the array holds DEPTH words; output stage is extra
	assign inReady = (count != (AW+1)'(DEPTH));
	assign push    = inValid & inReady;
	assign pop     = (count != '0) & (~outValid | outReady);

	// Array write, no reset needed on storage
	always_ff @(posedge sysClk)
	begin
		if (push)
			mem[wrPtr] <= inData;
	end

	// Pointers, occupancy and output register
	always_ff @(posedge sysClk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			wrPtr    <= '0;
			rdPtr    <= '0;
			count    <= '0;
			outValid <= 1'b0;
			outData  <= '0;
		end
		else
		begin
			if (push)
				wrPtr <= AW'(wrPtr + 1'b1);
			if (pop)
			begin
				rdPtr   <= AW'(rdPtr + 1'b1);
				outData <= mem[rdPtr];
			end
			count <= (AW+1)'(count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
			if (pop)
				outValid <= 1'b1;
			else if (outReady)
				outValid <= 1'b0;
		end
	end

endmodule

// ===== rtl/dwr_params.svh
// Constants for the write and refresh command block
`ifndef DWR_PARAMS_SVH
`define DWR_PARAMS_SVH

// Command encoding on {cs_n, ras_n, cas_n, we_n}
`define DWR_CMD_REF      4'h1
`define DWR_CMD_PRE      4'h2
`define DWR_CMD_ACT      4'h3
`define DWR_CMD_WRITE    4'h4
`define DWR_CMD_READ     4'h5

// Burst field of the first mode register
`define DWR_BL_FIXED8    2'h0
`define DWR_BL_OTF       2'h1
`define DWR_BL_FIXED4    2'h2

// Address bit positions
`define DWR_A_CHOP       12
`define DWR_A_ALLBANK    10
`define DWR_COL_MSB      9

// Beats per burst
`define DWR_BEATS_BL8    4'h8
`define DWR_BEATS_BC4    4'h4

// Widths
`define DWR_ADDR_W       14
`define DWR_BANK_W       3
`define DWR_NBANK        8
`define DWR_COL_W        10
`define DWR_DQ_W         8
`define DWR_ENTRY_W      26
`define DWR_FIFO_DEPTH   16
`define DWR_SYNC_W       32

// Sync vector bit positions
`define DWR_SV_CK        31
`define DWR_SV_CMD_HI    30
`define DWR_SV_CMD_LO    27
`define DWR_SV_ADDR_HI   26
`define DWR_SV_ADDR_LO   13
`define DWR_SV_BA_HI     12
`define DWR_SV_BA_LO     10
`define DWR_SV_DQS       9
`define DWR_SV_DQ_HI     8
`define DWR_SV_DQ_LO     1
`define DWR_SV_DM        0

// Timing
`define DWR_SYS_MHZ      40
`define DWR_TRFC_NS      110
`define DWR_TRFC_CYC     ((`DWR_TRFC_NS * `DWR_SYS_MHZ + 999) / 1000)
`define DWR_WINDOW_CK    8'h10

// Reset values
`define DWR_ROW_RST      14'h0000
`define DWR_BANKS_RST    8'h00

`endif

// ===== rtl/dwr_pkg.sv
// Types shared by the write and refresh command block
package dwr_pkg;

	typedef enum logic [2:0]
	{
		DWR_IDLE    = 3'b001,
		DWR_WDATA   = 3'b010,
		DWR_REFRESH = 3'b100
	} dwr_state_e;

endpackage
